// ---- bench/vdd_checker.sv ----
/* Port checker bound to vdd_decoder.
   Assumes CTRL changes only by word writes over the bus. */
`timescale 1ns/1ps
`default_nettype none
`include "vdd_defs.svh"
module vdd_checker (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hreadyout,
    input wire logic        pix_valid,
    input wire logic        pix_ready,
    input wire logic [7:0]  pixel_code,
    input wire logic        sync,
    input wire logic        blank,
    input wire logic        white_force,
    input wire logic        brighten,
    input wire logic        dac_valid,
    input wire logic        dac_ready,
    input wire logic [14:0] coarse_therm,
    input wire logic [3:0]  fine_bits,
    input wire logic        sync_en,
    input wire logic        blank_en,
    input wire logic        white_en,
    input wire logic        bright_en
);
    logic            pt_r;
    logic            wph_r;
    wire logic [3:0] en = {sync_en, blank_en, white_en, bright_en};
    wire logic       zc = coarse_therm == 15'h0 && fine_bits == 4'h0;
    wire logic [3:0] lo = pixel_code[3:0];
    wire logic       hit = hsel && htrans[1] && hwrite
                           && haddr[7:0] == `VDD_OFF_CTRL;
    // Mirror of the mode bit
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wph_r <= 1'b0;
            pt_r  <= 1'b0;
        end
        else if (hreadyout)
        begin
            wph_r <= hit;
            if (wph_r)
                pt_r <= hwdata[`VDD_CTRL_PT_BIT];
        end
    end
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    property p_therm;
        dac_valid |-> (coarse_therm & (coarse_therm + 15'h1)) == 15'h0;
    endproperty
    a_therm: assert property (p_therm)
        else $error("coarse code not thermometer");
    property p_sync;
        dac_valid && sync_en |-> en == 4'b1000 && zc;
    endproperty
    a_sync: assert property (p_sync)
        else $error("sync word not clean");
    property p_blank;
        dac_valid && blank_en |-> en == 4'b0100 && zc;
    endproperty
    a_blank: assert property (p_blank)
        else $error("blank word not clean");
    property p_white;
        dac_valid && white_en |-> en[3:2] == 2'b00
            && coarse_therm == 15'h7FFF && fine_bits == 4'hF;
    endproperty
    a_white: assert property (p_white)
        else $error("white word not full scale");
    property p_idle;
        !pt_r && !$past(pt_r) && !dac_valid |-> en == 4'h0 && zc;
    endproperty
    a_idle: assert property (p_idle)
        else $error("enable without word");
    property p_hold;
        !pt_r && dac_valid && !dac_ready |=> dac_valid
            && $stable(coarse_therm) && $stable(fine_bits) && $stable(en);
    endproperty
    a_hold: assert property (p_hold)
        else $error("word changed while stalled");
    property p_pt_rdy;
        pt_r && $past(pt_r) |-> pix_ready;
    endproperty
    a_pt_rdy: assert property (p_pt_rdy)
        else $error("source stalled in pass-through");
    property p_pt;
        pt_r && pix_valid && !sync && !blank && !white_force |=> dac_valid
            && fine_bits == $past(lo) && bright_en == $past(brighten);
    endproperty
    a_pt: assert property (p_pt)
        else $error("pass-through word wrong");
    property p_pt_sync;
        pt_r && pix_valid && sync |=> dac_valid && sync_en;
    endproperty
    a_pt_sync: assert property (p_pt_sync)
        else $error("sync lost in pass-through");
    c_reg: cover property (!pt_r && dac_valid && dac_ready);
    c_pt: cover property (pt_r && dac_valid);
    c_full: cover property (pix_valid && !pix_ready);
endmodule : vdd_checker
bind vdd_decoder vdd_checker u_vdd_checker (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hwdata(hwdata), .hreadyout(hreadyout), .pix_valid(pix_valid),
    .pix_ready(pix_ready), .pixel_code(pixel_code), .sync(sync),
    .blank(blank), .white_force(white_force), .brighten(brighten),
    .dac_valid(dac_valid), .dac_ready(dac_ready), .fine_bits(fine_bits),
    .coarse_therm(coarse_therm), .sync_en(sync_en), .blank_en(blank_en),
    .white_en(white_en), .bright_en(bright_en));
`default_nettype wire

// ---- bench/vdd_pix_src.sv ----
/* Pixel source model: random words, each held until taken.
   Assumes the bench seeds the generator once. */
`timescale 1ns/1ps
`default_nettype none
module vdd_pix_src (
    input  wire logic  hclk,
    input  wire logic  en,
    input  wire logic  pix_ready,
    output logic       pix_valid,
    output logic [7:0] pixel_code,
    output logic [3:0] ctl
);
    logic [31:0] r;
    initial
    begin
        pix_valid  = 1'b0;
        pixel_code = 8'h00;
        ctl        = 4'h0;
    end
    // Word and controls move together, at most one per edge
    always @(posedge hclk)
    begin
        r = $urandom;
        if (!pix_valid || pix_ready)
        begin
            pix_valid  <= en && r[1:0] != 2'b00;
            pixel_code <= r[2] ? r[15:8] : {8{r[3]}};
            ctl        <= {r[7:5] == 3'h0, r[7:5] == 3'h1,
                           r[7:5] == 3'h2, r[4]};
        end
    end
endmodule : vdd_pix_src
`default_nettype wire

// ---- bench/video_dac_input_decoder_tb.sv ----
/* Self-checking bench of vdd_decoder against a queue model.
   Assumes a zero-wait register slave on a 40 MHz hclk. */
`timescale 1ns/1ps
`default_nettype none
`include "vdd_defs.svh"
module video_dac_input_decoder_tb;
    logic             hclk      = 1'b0;
    logic             hresetn   = 1'b0;
    logic             hsel      = 1'b0;
    logic [31:0]      haddr     = 32'h0;
    logic [1:0]       htrans    = 2'h0;
    logic             hwrite    = 1'b0;
    logic [31:0]      hwdata    = 32'h0;
    logic             dac_ready = 1'b1;
    logic             en        = 1'b0;
    logic             stall     = 1'b0;
    logic             pt        = 1'b0;
    wire logic        hreadyout, hresp, pix_valid, pix_ready, dac_valid;
    wire logic [31:0] hrdata;
    wire logic [7:0]  pixel_code;
    wire logic [3:0]  ctl;
    wire logic [14:0] coarse_therm;
    wire logic [3:0]  fine_bits;
    wire logic        sync_en, blank_en, white_en, bright_en;
    int               miscompares = 0;
    int               check_count = 0;
    int               dcnt        = 0;
    logic [31:0]      rd;
    logic [11:0]      exp_q[$];
    logic [11:0]      cur_w;
    logic [11:0]      last_w    = 12'h000;
    always #12.5 hclk = ~hclk;
    vdd_decoder u_vdd_decoder (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .pix_valid(pix_valid),
        .pix_ready(pix_ready), .pixel_code(pixel_code), .sync(ctl[3]),
        .blank(ctl[2]), .white_force(ctl[1]), .brighten(ctl[0]),
        .dac_valid(dac_valid), .dac_ready(dac_ready),
        .coarse_therm(coarse_therm), .fine_bits(fine_bits),
        .sync_en(sync_en), .blank_en(blank_en), .white_en(white_en),
        .bright_en(bright_en));
    vdd_pix_src u_vdd_pix_src (.hclk(hclk), .en(en), .pix_ready(pix_ready),
        .pix_valid(pix_valid), .pixel_code(pixel_code), .ctl(ctl));
    function automatic logic [22:0] expect_of(logic [11:0] w);
        int th;
        th = (1 << w[7:4]) - 1;
        return w[11] ? {4'b1000, 19'h0} : w[10] ? {4'b0100, 19'h0} :
               w[9] ? {3'b001, w[8], 15'h7FFF, 4'hF} :
               {3'b000, w[8], th[14:0], w[3:0]};
    endfunction : expect_of
    function automatic logic [11:0] res_of(logic [11:0] w);
        return w[11] ? 12'h800 : w[10] ? 12'h400 :
               w[9] ? {3'b001, w[8], 8'hFF} : {3'b000, w[8], w[7:0]};
    endfunction : res_of
    task automatic check(logic [31:0] got, logic [31:0] want, string s);
        check_count++;
        if (got !== want)
        begin
            miscompares++;
            $display("wrong value at %0t: %s %h %h", $time, s, got, want);
        end
    endtask : check
    task automatic end_of_test;
        if (miscompares == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_of_test
    task automatic bus(logic wr, logic [7:0] a, logic [31:0] wd);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr  <= {24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus
    task automatic rdchk(logic [7:0] a, logic [31:0] want);
        bus(1'b0, a, 32'h0);
        check(rd, want, "register");
        check(hresp, 32'h0, "response");
    endtask : rdchk
    task automatic run(int n, logic st);
        stall <= st;
        en    <= 1'b1;
        repeat (n) @(posedge hclk);
        en    <= 1'b0;
        stall <= 1'b0;
        repeat (20) @(posedge hclk);
        check(exp_q.size(), 0, "words lost");
    endtask : run
    always @(posedge hclk)
    begin
        if (hresetn && dac_valid && dac_ready)
            dcnt++;
        if (hresetn && dac_valid && (dac_ready || pt))
        begin
            if (exp_q.size() == 0)
                check(1, 0, "extra word");
            else
            begin
                cur_w = exp_q.pop_front();
                check({sync_en, blank_en, white_en, bright_en, coarse_therm,
                    fine_bits}, expect_of(cur_w), "word");
                if (dac_ready)
                    last_w <= res_of(cur_w);
            end
        end
        if (hresetn && pix_valid && pix_ready)
            exp_q.push_back({ctl, pixel_code});
        dac_ready <= !stall || $urandom_range(2) != 0;
    end
    initial
    begin
        repeat (20000) @(posedge hclk);
        miscompares++;
        end_of_test();
    end
    initial
    begin
        void'($urandom(32));
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        rdchk(`VDD_OFF_CTRL, 32'h0);
        bus(1'b1, 8'h40, 32'hFFFF_FFFF);
        rdchk(8'h40, 32'h0);
        run(400, 1'b1);
        rdchk(`VDD_OFF_COUNT, dcnt);
        bus(1'b1, `VDD_OFF_COUNT, 32'h0);
        dcnt = 0;
        rdchk(`VDD_OFF_COUNT, 32'h0);
        bus(1'b1, `VDD_OFF_CTRL, 32'h1);
        pt = 1'b1;
        rdchk(`VDD_OFF_STATUS, 32'h5);
        run(300, 1'b1);
        rdchk(`VDD_OFF_COUNT, dcnt);
        bus(1'b1, `VDD_OFF_CTRL, 32'h0);
        pt = 1'b0;
        rdchk(`VDD_OFF_STATUS, 32'h4);
        run(200, 1'b0);
        rdchk(`VDD_OFF_LAST, {20'h0, last_w});
        end_of_test();
    end
endmodule : video_dac_input_decoder_tb
`default_nettype wire

// ---- verilog/vdd_buffer.sv ----
/*
 * Small FIFO buffer with valid/ready on both sides and a flush input.
 * Assumes one clock and an active-low asynchronous reset.
 */
`timescale 1ns/1ps
`default_nettype none
module vdd_buffer #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 2
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic flush,
    vdd_stream_if.snk in_s,
    vdd_stream_if.src out_s
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [PW-1:0]    wr_ptr_r;
    logic [PW-1:0]    rd_ptr_r;
    logic [CW-1:0]    count_r;
    logic [CW-1:0]    count_nxt;
    logic             ready_r;
    wire              push;
    wire              pop;

    assign push        = in_s.valid & ready_r & ~flush;
    assign pop         = out_s.valid & out_s.ready & ~flush;
    assign out_s.valid = (count_r != '0);
    assign out_s.data  = mem_r[rd_ptr_r];
    assign in_s.ready  = ready_r;
    assign count_nxt   = flush ? '0 :
                         CW'(count_r + CW'(push) - CW'(pop));

    function automatic logic [PW-1:0] wrap_inc(input logic [PW-1:0] p);
        wrap_inc = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + PW'(1));
    endfunction : wrap_inc

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
            ready_r  <= 1'b1;
        end
        else
        begin
            wr_ptr_r <= flush ? '0 : (push ? wrap_inc(wr_ptr_r) : wr_ptr_r);
            rd_ptr_r <= flush ? '0 : (pop ? wrap_inc(rd_ptr_r) : rd_ptr_r);
            count_r  <= count_nxt;
            ready_r  <= (count_nxt != CW'(DEPTH));
        end
    end

    always_ff @(posedge clk)
    begin
        if (push)
            mem_r[wr_ptr_r] <= in_s.data;
    end
endmodule : vdd_buffer
`default_nettype wire

// ---- verilog/vdd_decoder.sv ----
/*
 * Digital front end of the 8-bit video DAC: control priority, segment
 * decode, registered or pass-through path, and an AHB-Lite register slave.
 * Assumes the pixel source and the bus master run on hclk; the
 * convert clock is hclk itself.
 */
`timescale 1ns/1ps
`default_nettype none
`include "vdd_defs.svh"
module vdd_decoder (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        pix_valid,
    output logic             pix_ready,
    input  wire logic [7:0]  pixel_code,
    input  wire logic        sync,
    input  wire logic        blank,
    input  wire logic        white_force,
    input  wire logic        brighten,
    output logic             dac_valid,
    input  wire logic        dac_ready,
    output logic [14:0]      coarse_therm,
    output logic [3:0]       fine_bits,
    output logic             sync_en,
    output logic             blank_en,
    output logic             white_en,
    output logic             bright_en
);
    import vdd_pkg::*;

    localparam int BUF_DEPTH = 2;

    // Register state
    logic              passthrough_select_r;
    logic [31:0]       count_r;
    logic [31:0]       count_nxt;
    vdd_word_t         last_r;
    logic              hreadyout_r;
    logic [31:0]       hrdata_r;
    logic              wr_pend_r;
    logic [7:0]        wr_addr_r;

    // Output stage state
    vdd_word_t         out_word_r;
    logic              out_v_r;
    logic [14:0]       coarse_r;

    // Bus decode
    wire               addr_phase;
    wire               wr_phase;
    wire               rd_phase;
    wire  [7:0]        addr_lo;
    logic [31:0]       rd_mux;

    // Datapath
    vdd_word_t         in_word;
    wire               pt_mode;
    wire               buf_pop;
    wire               out_load;
    wire  [3:0]        out_coarse_nxt;
    wire               delivered;

    vdd_stream_if #(.WIDTH(VDD_WORD_W)) in_st ();
    vdd_stream_if #(.WIDTH(VDD_WORD_W)) out_st ();

    // Address match, used by both read and write decode
    function automatic logic reg_hit(input logic [7:0] a,
                                     input logic [7:0] off);
        reg_hit = (a == off);
    endfunction : reg_hit

    // Control priority: sync, then blank, then white force
    function automatic vdd_word_t resolve(input logic [7:0] code,
                                          input logic       s,
                                          input logic       b,
                                          input logic       w,
                                          input logic       br);
        vdd_word_t r;
        r             = '0;
        r.sync_en     = s;
        r.blank_en    = ~s & b;
        r.white_en    = ~s & ~b & w;
        r.bright_en   = ~s & ~b & br;
        if (s | b)
        begin
            r.coarse_code = `VDD_NIB_ZERO;
            r.fine_code   = `VDD_NIB_ZERO;
        end
        else if (w)
        begin
            r.coarse_code = `VDD_NIB_FULL;
            r.fine_code   = `VDD_NIB_FULL;
        end
        else
        begin
            r.coarse_code = code[7:4];
            r.fine_code   = code[3:0];
        end
        resolve = r;
    endfunction : resolve

    // AHB-Lite address phase and register decode
    assign addr_phase = hsel & htrans[1] & hready;
    assign wr_phase   = addr_phase & hwrite;
    assign rd_phase   = addr_phase & ~hwrite;
    assign addr_lo    = {haddr[7:2], 2'b00};

    always_comb
    begin
        rd_mux = 32'h0000_0000;
        if (reg_hit(addr_lo, `VDD_OFF_CTRL))
            rd_mux[`VDD_CTRL_PT_BIT] = passthrough_select_r;
        else if (reg_hit(addr_lo, `VDD_OFF_STATUS))
        begin
            rd_mux[`VDD_ST_PT_BIT]   = passthrough_select_r;
            rd_mux[`VDD_ST_OUTV_BIT] = out_v_r;
            rd_mux[`VDD_ST_RDY_BIT]  = pix_ready;
        end
        else if (reg_hit(addr_lo, `VDD_OFF_LAST))
            rd_mux[VDD_WORD_W-1:0] = last_r;
        else if (reg_hit(addr_lo, `VDD_OFF_COUNT))
            rd_mux = count_r;
        else
            rd_mux = 32'h0000_0000;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_r   <= 1'b0;
            wr_addr_r   <= 8'h00;
            hrdata_r    <= 32'h0000_0000;
            hreadyout_r <= 1'b1;
        end
        else
        begin
            wr_pend_r   <= wr_phase;
            wr_addr_r   <= addr_lo;
            hrdata_r    <= rd_phase ? rd_mux : hrdata_r;
            hreadyout_r <= 1'b1;
        end
    end

    // Pass-through select; low after reset selects registered mode
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            passthrough_select_r <= 1'(`VDD_CTRL_RESET);
        else if (wr_pend_r && reg_hit(wr_addr_r, `VDD_OFF_CTRL))
            passthrough_select_r <= hwdata[`VDD_CTRL_PT_BIT];
    end

    // Delivered-word counter; a write clears it, a delivery in the same cycle still counts (leaves 1)
    assign count_nxt = (wr_pend_r && reg_hit(wr_addr_r, `VDD_OFF_COUNT))
                       ? 32'h0000_0000 : count_r;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            count_r <= 32'h0000_0000;
        else
            count_r <= delivered ? count_nxt + 32'h0000_0001 : count_nxt;
    end

    // Pixel word resolved before any register stage
    assign pt_mode = passthrough_select_r;
    assign in_word = resolve(pixel_code, sync, blank,
                             white_force, brighten);

    assign in_st.data  = in_word;
    assign in_st.valid = pix_valid & ~pt_mode;

    vdd_buffer #(
        .WIDTH (VDD_WORD_W),
        .DEPTH (BUF_DEPTH)
    ) u_buffer (
        .clk   (hclk),
        .rst_n (hresetn),
        .flush (pt_mode),
        .in_s  (in_st),
        .out_s (out_st)
    );

    // Output register: in registered mode loads when empty or when the receiver takes it; in pass-through, every cycle
    assign out_load     = ~out_v_r | dac_ready;
    assign out_st.ready = out_load & ~pt_mode;
    assign buf_pop      = out_st.valid & out_st.ready;
    assign delivered    = out_v_r & dac_ready;

    assign out_coarse_nxt = pt_mode ? in_word.coarse_code
                                    : out_st.data[7:4];

    // Thermometer: switch i is on when the coarse nibble exceeds i
    genvar gi;
    generate
        for (gi = 0; gi < 15; gi++)
        begin : g_therm
            wire therm_on;
            assign therm_on = (out_coarse_nxt > 4'(gi));

            always_ff @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                    coarse_r[gi] <= 1'b0;
                else if (pt_mode || (out_load && buf_pop))
                    coarse_r[gi] <= therm_on;
                else if (out_load)
                    coarse_r[gi] <= 1'b0;
            end
        end
    endgenerate

    // Registered mode takes the buffer head; pass-through takes the input
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            out_word_r <= '0;
            out_v_r    <= 1'b0;
        end
        else if (pt_mode)
        begin
            out_word_r <= in_word;
            out_v_r    <= pix_valid;
        end
        else if (out_load)
        begin
            out_word_r <= buf_pop ? vdd_word_t'(out_st.data) : '0;
            out_v_r    <= buf_pop;
        end
    end

    // Last delivered word, visible to software
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            last_r <= '0;
        else if (delivered)
            last_r <= out_word_r;
    end

    // Outputs straight from flops except hresp, tied low; one enable per control current
    assign hreadyout    = hreadyout_r;
    assign hresp        = 1'b0;
    assign hrdata       = hrdata_r;
    assign pix_ready    = in_st.ready;
    assign dac_valid    = out_v_r;
    assign coarse_therm = coarse_r;
    assign fine_bits    = out_word_r.fine_code;
    assign sync_en      = out_word_r.sync_en;
    assign blank_en     = out_word_r.blank_en;
    assign white_en     = out_word_r.white_en;
    assign bright_en    = out_word_r.bright_en;
endmodule : vdd_decoder
`default_nettype wire

// ---- verilog/vdd_defs.svh ----
/*
 * Constants of the video DAC input decoder: register offsets, field
 * positions, reset values and timing counts.
 * Assumes it is included by bare name by the top module, the checker and the bench.
 */
`ifndef VDD_DEFS_SVH
`define VDD_DEFS_SVH

`define VDD_OFF_CTRL       8'h00
`define VDD_OFF_STATUS     8'h04
`define VDD_OFF_LAST       8'h08
`define VDD_OFF_COUNT      8'h0C

`define VDD_CTRL_PT_BIT    0
`define VDD_CTRL_RESET     32'h0000_0000

`define VDD_ST_PT_BIT      0
`define VDD_ST_OUTV_BIT    1
`define VDD_ST_RDY_BIT     2

`define VDD_NIB_FULL       4'hF
`define VDD_NIB_ZERO       4'h0

`define VDD_CLK_MHZ        40
`define VDD_MAX_RATE_MWPS  400
`define VDD_WORD_CYCLES \
    (((`VDD_CLK_MHZ + `VDD_MAX_RATE_MWPS - 1) / `VDD_MAX_RATE_MWPS) < 1 ? 1 : \
     ((`VDD_CLK_MHZ + `VDD_MAX_RATE_MWPS - 1) / `VDD_MAX_RATE_MWPS))

`endif

// ---- verilog/vdd_pkg.sv ----
/*
 * Types of the video DAC input decoder.
 * Assumes nothing beyond the constants header.
 */
`default_nettype none
package vdd_pkg;

    typedef struct packed {
        logic       sync_en;
        logic       blank_en;
        logic       white_en;
        logic       bright_en;
        logic [3:0] coarse_code;
        logic [3:0] fine_code;
    } vdd_word_t;

    localparam int VDD_WORD_W = $bits(vdd_word_t);

endpackage : vdd_pkg
`default_nettype wire

// ---- verilog/vdd_stream_if.sv ----
/*
 * Valid/ready stream carrying resolved words between design modules.
 * Assumes one source and one sink on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface vdd_stream_if #(parameter int WIDTH = 12);
    logic [WIDTH-1:0] data;
    logic             valid;
    logic             ready;

    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface : vdd_stream_if
`default_nettype wire
